/* File: rtl/ibx_exec.sv */
// Purpose: Decode and execute for add-immediate, branch, count, field, divide and return ops
// Assumes: Operands are read from the register file the cycle the instruction is issued
// Notes: Divide is iterative and the hazard barrier stalls while hazards are pending; all other ops finish in the issue cycle
//
// What this block does
// RQ1 - Add immediate with wraparound, no overflow
// RQ2 - Compressed mode adds immediate to program counter
// RQ3 - Short branch always taken, adds offset
// RQ4 - Branch-always-link always taken, writes link
// RQ5 - Equal/not-equal branches compare two sources
// RQ6 - Nonnegative branch taken when sign clear
// RQ7 - Link forms write pc plus eight always
// RQ8 - Positive branch: sign clear and nonzero
// RQ9 - Nonpositive branch: sign set or zero
// RQ10 - Negative branch taken when sign set
// RQ11 - Likely branches nullify slot when untaken
// RQ12 - Coprocessor false branch taken on zero
// RQ13 - Coprocessor true branch taken on one
// RQ14 - Count leading zeros or leading ones
// RQ15 - Move control words to/from coprocessor
// RQ16 - Debug return loads pc, exits debug
// RQ17 - Interrupt toggles copy status, update enable
// RQ18 - Divide: quotient low, remainder high
// RQ19 - Hazard barrier stalls until hazards clear
// RQ20 - Exception return picks target, clears flags
// RQ21 - Field extract right-justifies selected field
// RQ22 - Field insert replaces only target field
// RQ23 - Unknown or absent-coprocessor ops trap
`include "ibx_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ibx_exec
	import ibx_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic issue_valid,
	input wire ibx_issue_t issue,
	input wire logic cop_present,
	input wire logic [7:0] cop_cond,
	input wire logic [31:0] cop_ctrl_rdata,
	input wire logic hazard_pending,
	input wire logic [31:0] exc_return_pc,
	input wire logic [31:0] error_return_pc,
	input wire logic [31:0] debug_return_pc,
	output logic busy,
	output ibx_wb_t wb,
	output logic redirect,
	output logic [31:0] redirect_pc,
	output logic nullify_next,
	output logic cop_ctrl_we,
	output logic [4:0] cop_ctrl_idx,
	output logic [31:0] cop_ctrl_wdata,
	output logic [31:0] status_word,
	output logic link_reservation_flag,
	output logic debug_mode,
	output logic [31:0] result_high_word,
	output logic [31:0] result_low_word,
	output logic exc_reserved,
	output logic exc_cop_unusable
);
	logic [5:0] op;
	logic [5:0] fn;
	logic [4:0] rs;
	logic [4:0] rt;
	logic [4:0] rd;
	logic [4:0] sa;
	logic [31:0] imm_sx;
	logic [31:0] br_target;
	logic a_neg;
	logic a_zero;
	logic take;
	logic cond_br;
	logic likely;
	logic link;
	logic is_cop_op;
	logic valid_op;
	logic [31:0] ovr_data;
	logic [4:0] ovr_idx;
	logic ovr_we;
	logic do_exception_return;
	logic do_debug_return;
	logic do_di;
	logic do_ei;
	logic do_div;
	logic do_ehb;
	logic [5:0] lead_cnt;
	logic [31:0] field_mask;
	logic [31:0] next_status;
	logic [5:0] msb;
	logic go;
	ibx_state_t state;
	logic [5:0] div_cnt;
	logic [31:0] div_q;
	logic [31:0] div_r;
	logic [31:0] div_d;
	logic div_neg_q;
	logic div_neg_r;
	logic [33:0] div_trial;
	logic div_signed;

	// Field split of the issued word
	assign op = issue.instr[31:26];
	assign rs = issue.instr[25:21];
	assign rt = issue.instr[20:16];
	assign rd = issue.instr[15:11];
	assign sa = issue.instr[10:6];
	assign fn = issue.instr[5:0];
	assign imm_sx = {{16{issue.instr[15]}}, issue.instr[15:0]};
	assign br_target = issue.pc + `IBX_PC_STEP + {imm_sx[29:0], 2'b00};
	assign a_neg = issue.src_a[31];
	assign a_zero = (issue.src_a == 32'h0000_0000);
	// Nothing issues while a divide or barrier is in flight
	assign go = issue_valid && (state == IBX_IDLE);

	// Leading count: invert for ones so one priority scan serves both
	always_comb begin
		logic [31:0] v;
		v = (fn == `IBX_FN_CLO) ? ~issue.src_a : issue.src_a; // see RQ14
		lead_cnt = 6'h20;
		for (int i = 0; i < 32; i++) begin
			if (v[i]) begin
				lead_cnt = 6'(31 - i);
			end
		end
	end

	// Field mask from position and msb/lsb encodings
	always_comb begin
		msb = (fn == `IBX_FN_EXT) ? 6'({1'b0, rd}) : 6'({1'b0, rd} - {1'b0, sa});
		field_mask = 32'h0000_0000;
		for (int i = 0; i < 32; i++) begin
			if (i <= int'(msb)) begin
				field_mask[i] = 1'b1;
			end
		end
	end

	// Main decode: condition, link, writeback and side-effect selection
	always_comb begin
		take = 1'b0;
		cond_br = 1'b0;
		likely = 1'b0;
		link = 1'b0;
		is_cop_op = 1'b0;
		valid_op = 1'b1;
		ovr_we = 1'b0;
		ovr_idx = rt;
		ovr_data = 32'h0000_0000;
		do_exception_return = 1'b0;
		do_debug_return = 1'b0;
		do_di = 1'b0;
		do_ei = 1'b0;
		do_div = 1'b0;
		do_ehb = 1'b0;
		unique case (op)
			`IBX_OP_ADD_IMM_MODULAR: begin
				ovr_we = 1'b1;
				ovr_data = issue.src_a + imm_sx; // see RQ1
			end
			`IBX_OP_ADD_IMM_TO_PC: begin
				valid_op = issue.compressed; // see RQ2
				ovr_we = issue.compressed;
				ovr_data = issue.pc + imm_sx; // see RQ2
			end
			`IBX_OP_BEQ, `IBX_OP_BEQL: begin
				cond_br = 1'b1;
				likely = (op == `IBX_OP_BEQL);
				take = (issue.src_a == issue.src_b); // see RQ5 see RQ3
			end
			`IBX_OP_BNE, `IBX_OP_BNEL: begin
				cond_br = 1'b1;
				likely = (op == `IBX_OP_BNEL);
				take = (issue.src_a != issue.src_b); // see RQ5
			end
			`IBX_OP_BRANCH_POSITIVE, `IBX_OP_BGTZL: begin
				cond_br = 1'b1;
				likely = (op == `IBX_OP_BGTZL);
				take = !a_neg && !a_zero; // see RQ8
			end
			`IBX_OP_BRANCH_NONPOSITIVE, `IBX_OP_BLEZL: begin
				cond_br = 1'b1;
				likely = (op == `IBX_OP_BLEZL);
				take = a_neg || a_zero; // see RQ9
			end
			`IBX_OP_REGIMM: begin
				cond_br = 1'b1;
				likely = rt[1];
				link = rt[4];
				take = rt[0] ? !a_neg : a_neg; // see RQ6 see RQ10 see RQ4
				valid_op = (rt[3:2] == 2'b00) && (rt[4] == 1'b0 || rt[4:0] <= `IBX_RT_BGEZALL);
			end
			`IBX_OP_COP2: begin
				is_cop_op = 1'b1;
				if (rs == `IBX_RS_BC) begin
					cond_br = 1'b1;
					likely = rt[1];
					take = (cop_cond[rt[4:2]] == rt[0]); // see RQ12 see RQ13
				end else if (rs == `IBX_RS_CFC) begin
					ovr_we = 1'b1;
					ovr_data = cop_ctrl_rdata; // see RQ15
				end else begin
					valid_op = (rs == `IBX_RS_CTC) || rs[4];
				end
			end
			`IBX_OP_SPECIAL2: begin
				ovr_we = (fn == `IBX_FN_CLZ) || (fn == `IBX_FN_CLO);
				valid_op = ovr_we;
				ovr_idx = rd;
				ovr_data = {26'h0000000, lead_cnt}; // see RQ14
			end
			`IBX_OP_SPECIAL3: begin
				ovr_we = (fn == `IBX_FN_EXT) || (fn == `IBX_FN_INS);
				valid_op = ovr_we;
				if (fn == `IBX_FN_EXT) begin
					ovr_data = (issue.src_a >> sa) & field_mask; // see RQ21
				end else begin
					ovr_data = (issue.src_b & ~(field_mask << sa))
						| ((issue.src_a & field_mask) << sa); // see RQ22
				end
			end
			`IBX_OP_SPECIAL: begin
				do_div = (fn == `IBX_FN_DIV) || (fn == `IBX_FN_DIVIDE_UNSIGNED);
				do_ehb = (fn == `IBX_FN_SLL) && (issue.instr[25:6] == {15'h0000, `IBX_SA_EHB});
				valid_op = do_div || do_ehb || (issue.instr == 32'h0000_0000);
			end
			`IBX_OP_COP0: begin
				do_exception_return = (rs == `IBX_RS_CO) && (fn == `IBX_FN_EXCEPTION_RETURN);
				do_debug_return = (rs == `IBX_RS_CO) && (fn == `IBX_FN_DEBUG_RETURN);
				do_di = (rs == `IBX_RS_MFMC0) && !issue.instr[5];
				do_ei = (rs == `IBX_RS_MFMC0) && issue.instr[5];
				ovr_we = do_di || do_ei;
				ovr_data = status_word; // see RQ17
				valid_op = do_exception_return || do_debug_return || do_di || do_ei;
			end
			default: begin
				valid_op = 1'b0; // see RQ23
			end
		endcase
	end

	// Traps take priority; nothing trapped may write or redirect
	assign exc_reserved = go && !valid_op; // see RQ23
	assign exc_cop_unusable = go && valid_op && is_cop_op && !cop_present; // see RQ23

	// Writeback and redirect are handshake-style combinational results
	always_comb begin
		logic ok;
		ok = go && valid_op && !(is_cop_op && !cop_present);
		wb.wr_en = ok && (ovr_we || link);
		wb.wr_idx = link ? `IBX_LINK_REG : ovr_idx;
		wb.wr_data = link ? issue.pc + `IBX_LINK_OFS : ovr_data; // see RQ7 see RQ4
		redirect = ok && ((cond_br && take) || do_exception_return || do_debug_return);
		redirect_pc = br_target;
		if (do_exception_return) begin
			redirect_pc = status_word[`IBX_SR_ERL] ? error_return_pc : exc_return_pc; // see RQ20
		end else if (do_debug_return) begin
			redirect_pc = debug_return_pc; // see RQ16
		end
		nullify_next = ok && cond_br && likely && !take; // see RQ11 see RQ13
		cop_ctrl_we = ok && is_cop_op && (rs == `IBX_RS_CTC);
		cop_ctrl_idx = rd;
		cop_ctrl_wdata = issue.src_b; // see RQ15
	end

	// Status word, reservation flag and debug mode updates
	always_comb begin
		next_status = status_word;
		if (do_di || do_ei) begin
			next_status[`IBX_SR_IE] = do_ei; // see RQ17
		end
		if (do_exception_return) begin
			if (status_word[`IBX_SR_ERL]) begin
				next_status[`IBX_SR_ERL] = 1'b0;
			end else begin
				next_status[`IBX_SR_EXL] = 1'b0; // see RQ20
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			status_word <= `IBX_SR_RESET;
			link_reservation_flag <= 1'b0;
			debug_mode <= 1'b0;
		end else if (go && valid_op) begin
			status_word <= next_status;
			if (do_exception_return) begin
				link_reservation_flag <= 1'b0; // see RQ20
			end
			if (do_debug_return) begin
				debug_mode <= 1'b0; // see RQ16
			end
		end
	end

	// Restoring divider: magnitudes in, signs fixed at the end
	// Two guard bits keep the borrow visible even for divisors with bit 31 set
	assign div_trial = {1'b0, div_r, div_q[31]} - {2'b00, div_d};
	assign div_signed = (fn == `IBX_FN_DIV); // see RQ18
	assign busy = (state != IBX_IDLE);

	always_ff @(posedge mclk) begin
		if (srst) begin
			state <= IBX_IDLE;
			div_cnt <= 6'h00;
			div_q <= 32'h0000_0000;
			div_r <= 32'h0000_0000;
			div_d <= 32'h0000_0000;
			div_neg_q <= 1'b0;
			div_neg_r <= 1'b0;
			result_high_word <= 32'h0000_0000;
			result_low_word <= 32'h0000_0000;
		end else begin
			unique case (state)
				IBX_IDLE: begin
					if (go && do_div) begin
						div_q <= (div_signed && issue.src_a[31]) ? -issue.src_a : issue.src_a;
						div_d <= (div_signed && issue.src_b[31]) ? -issue.src_b : issue.src_b;
						div_neg_q <= div_signed && (issue.src_a[31] ^ issue.src_b[31]);
						div_neg_r <= div_signed && issue.src_a[31];
						div_r <= 32'h0000_0000;
						div_cnt <= `IBX_DIV_STEPS;
						state <= IBX_DIV;
					end else if (go && do_ehb && hazard_pending) begin
						state <= IBX_BAR; // see RQ19
					end
				end
				IBX_DIV: begin
					if (div_cnt == 6'h00) begin
						result_low_word <= div_neg_q ? -div_q : div_q; // see RQ18
						result_high_word <= div_neg_r ? -div_r : div_r; // see RQ18
						state <= IBX_IDLE;
					end else begin
						div_cnt <= div_cnt - 6'h01;
						if (!div_trial[33]) begin
							div_r <= div_trial[31:0];
							div_q <= {div_q[30:0], 1'b1};
						end else begin
							div_r <= {div_r[30:0], div_q[31]};
							div_q <= {div_q[30:0], 1'b0};
						end
					end
				end
				IBX_BAR: begin
					if (!hazard_pending) begin
						state <= IBX_IDLE; // see RQ19
					end
				end
				default: begin
					state <= IBX_IDLE;
				end
			endcase
		end
	end

	// Barrier holds issue off for as long as any hazard is outstanding
	barrier_hold_a: assert property (@(posedge mclk) disable iff (srst)
		(state == IBX_BAR && hazard_pending) |=> busy) else $error("barrier released early"); // see RQ19
	div_len_a: assert property (@(posedge mclk) disable iff (srst)
		(state == IBX_IDLE && go && do_div) |=> busy [*8]) else $error("divide too short"); // see RQ18
	add_imm_modular_sum_a: assert property (@(posedge mclk) disable iff (srst)
		(go && op == `IBX_OP_ADD_IMM_MODULAR) |-> (wb.wr_en && wb.wr_data == issue.src_a + imm_sx))
		else $error("add immediate wrong"); // see RQ1
	link_data_a: assert property (@(posedge mclk) disable iff (srst)
		(wb.wr_en && link) |-> (wb.wr_idx == `IBX_LINK_REG && wb.wr_data == issue.pc + `IBX_LINK_OFS))
		else $error("link value wrong"); // see RQ7
	likely_null_a: assert property (@(posedge mclk) disable iff (srst)
		nullify_next |-> !redirect) else $error("nullify with taken branch"); // see RQ11
	exception_return_flag_a: assert property (@(posedge mclk) disable iff (srst)
		(redirect && do_exception_return) |=> !link_reservation_flag) else $error("reservation not cleared"); // see RQ20
	ie_update_a: assert property (@(posedge mclk) disable iff (srst)
		(go && (do_di || do_ei)) |=> status_word[`IBX_SR_IE] == $past(do_ei))
		else $error("enable bit wrong"); // see RQ17
	trap_quiet_a: assert property (@(posedge mclk) disable iff (srst)
		(exc_reserved || exc_cop_unusable) |-> (!wb.wr_en && !redirect && !cop_ctrl_we))
		else $error("trapped op had effect"); // see RQ23
	debug_return_exit_a: assert property (@(posedge mclk) disable iff (srst)
		(redirect && do_debug_return) |-> (redirect_pc == debug_return_pc) ##1 !debug_mode)
		else $error("debug return wrong"); // see RQ16
endmodule : ibx_exec
`default_nettype wire

/* File: rtl/ibx_params.svh */
// Purpose: Named constants for the integer/branch execute block
// Assumes: 32-bit datapath, standard 32-bit instruction encoding
// Notes: Opcode and function fields follow the usual 32-bit layout
`ifndef IBX_PARAMS_SVH
`define IBX_PARAMS_SVH
`define IBX_OP_SPECIAL 6'h00
`define IBX_OP_REGIMM 6'h01
`define IBX_OP_BEQ 6'h04
`define IBX_OP_BNE 6'h05
`define IBX_OP_BRANCH_NONPOSITIVE 6'h06
`define IBX_OP_BRANCH_POSITIVE 6'h07
`define IBX_OP_ADD_IMM_MODULAR 6'h09
`define IBX_OP_COP0 6'h10
`define IBX_OP_COP2 6'h12
`define IBX_OP_BEQL 6'h14
`define IBX_OP_BNEL 6'h15
`define IBX_OP_BLEZL 6'h16
`define IBX_OP_BGTZL 6'h17
`define IBX_OP_SPECIAL2 6'h1c
`define IBX_OP_SPECIAL3 6'h1f
`define IBX_OP_ADD_IMM_TO_PC 6'h3b
`define IBX_FN_SLL 6'h00
`define IBX_FN_DIV 6'h1a
`define IBX_FN_DIVIDE_UNSIGNED 6'h1b
`define IBX_FN_CLZ 6'h20
`define IBX_FN_CLO 6'h21
`define IBX_FN_EXT 6'h00
`define IBX_FN_INS 6'h04
`define IBX_FN_EXCEPTION_RETURN 6'h18
`define IBX_FN_DEBUG_RETURN 6'h1f
`define IBX_RT_BRANCH_NEGATIVE 5'h00
`define IBX_RT_BRANCH_NONNEG 5'h01
`define IBX_RT_BLTZL 5'h02
`define IBX_RT_BGEZL 5'h03
`define IBX_RT_BLTZAL 5'h10
`define IBX_RT_BRANCH_NONNEG_LINK 5'h11
`define IBX_RT_BLTZALL 5'h12
`define IBX_RT_BGEZALL 5'h13
`define IBX_RS_CFC 5'h02
`define IBX_RS_CTC 5'h06
`define IBX_RS_BC 5'h08
`define IBX_RS_MFMC0 5'h0b
`define IBX_RS_CO 5'h10
`define IBX_SA_EHB 5'h03
`define IBX_LINK_REG 5'h1f
`define IBX_LINK_OFS 32'h0000_0008
`define IBX_SR_IE 0
`define IBX_SR_EXL 1
`define IBX_SR_ERL 2
`define IBX_DIV_STEPS 6'h20
`define IBX_SR_RESET 32'h0000_0004
`define IBX_PC_STEP 32'h0000_0004
`endif

/* File: rtl/ibx_pkg.sv */
// Purpose: Types shared by the integer/branch execute block
// Assumes: Included constants header provides the numbers
// Notes: Structs carry grouped operand and result signals
package ibx_pkg;
	typedef struct packed {
		logic [31:0] instr;
		logic [31:0] pc;
		logic [31:0] src_a;
		logic [31:0] src_b;
		logic compressed;
	} ibx_issue_t;
	typedef struct packed {
		logic wr_en;
		logic [4:0] wr_idx;
		logic [31:0] wr_data;
	} ibx_wb_t;
	typedef enum logic [1:0] {
		IBX_IDLE = 2'b00,
		IBX_DIV = 2'b01,
		IBX_BAR = 2'b11
	} ibx_state_t;
endpackage : ibx_pkg

/* File: test/ibx_cop_model.sv */
// Purpose: Behavioural coprocessor 2 standing beside the execute block
// Assumes: Control words are read back combinationally by index
// Notes: Condition bits come from the bench; unwritten words read as X on purpose
`timescale 1ns/1ps
`default_nettype none
module ibx_cop_model (
	input wire logic mclk,
	input wire logic [7:0] cond_in,
	input wire logic cop_ctrl_we,
	input wire logic [4:0] cop_ctrl_idx,
	input wire logic [31:0] cop_ctrl_wdata,
	output logic [7:0] cop_cond,
	output logic [31:0] cop_ctrl_rdata
);
	logic [31:0] ccr [32];
	// Accept control words on the write pulse
	always_ff @(posedge mclk) begin
		if (cop_ctrl_we) begin
			ccr[cop_ctrl_idx] <= cop_ctrl_wdata;
		end
	end
	// Return words and supply the condition bits for every code
	assign cop_ctrl_rdata = ccr[cop_ctrl_idx];
	assign cop_cond = cond_in;
endmodule : ibx_cop_model
`default_nettype wire

/* File: test/tb_top.sv */
// Purpose: Self-checking bench for the integer/branch execute block
// Assumes: Outputs settle within half a cycle of the issue
// Notes: Every branch uses pc 0x1000 and offset -2 words
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ibx_pkg::*;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic issue_valid = 1'b0;
	ibx_issue_t issue = '0;
	logic cop_present = 1'b1;
	logic [7:0] cond_in = 8'h04;
	logic [7:0] cop_cond;
	logic [31:0] cop_ctrl_rdata;
	logic hazard_pending = 1'b0;
	logic cmode = 1'b0;
	logic busy, redirect, nullify_next, cop_ctrl_we, llf, dbg, exr, exu;
	ibx_wb_t wb;
	logic [31:0] redirect_pc, cop_ctrl_wdata, status_word, hi, lo;
	logic [4:0] cop_ctrl_idx;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	ibx_exec dut_u (.mclk(mclk), .srst(srst), .issue_valid(issue_valid), .issue(issue),
		.cop_present(cop_present), .cop_cond(cop_cond), .cop_ctrl_rdata(cop_ctrl_rdata),
		.hazard_pending(hazard_pending), .exc_return_pc(32'h0000_2000),
		.error_return_pc(32'h0000_3000), .debug_return_pc(32'h0000_4000), .busy(busy),
		.wb(wb), .redirect(redirect), .redirect_pc(redirect_pc), .nullify_next(nullify_next),
		.cop_ctrl_we(cop_ctrl_we), .cop_ctrl_idx(cop_ctrl_idx), .cop_ctrl_wdata(cop_ctrl_wdata),
		.status_word(status_word), .link_reservation_flag(llf), .debug_mode(dbg),
		.result_high_word(hi), .result_low_word(lo), .exc_reserved(exr), .exc_cop_unusable(exu));
	ibx_cop_model cop_u (.mclk(mclk), .cond_in(cond_in), .cop_ctrl_we(cop_ctrl_we),
		.cop_ctrl_idx(cop_ctrl_idx), .cop_ctrl_wdata(cop_ctrl_wdata), .cop_cond(cop_cond),
		.cop_ctrl_rdata(cop_ctrl_rdata));
	// Clock and a ceiling well above the roughly 130 cycles the run needs
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			test_done();
		end
	end
	task automatic test_done;
		if (n_errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Present one instruction and leave it until the next edge takes it
	task automatic go(input logic [31:0] i, input logic [31:0] a, input logic [31:0] b);
		@(posedge mclk);
		#1;
		issue = '{i, 32'h0000_1000, a, b, cmode};
		issue_valid = 1'b1;
		#12;
	endtask : go
	task automatic idle;
		@(posedge mclk);
		#1;
		issue_valid = 1'b0;
	endtask : idle
	task automatic chk_wb(input logic en, input logic [4:0] idx, input logic [31:0] d);
		chk("wr_en", {31'h0, en}, {31'h0, wb.wr_en});
		if (en) begin
			chk("wr_idx", {27'h0, idx}, {27'h0, wb.wr_idx});
			chk("wr_data", d, wb.wr_data);
		end
	endtask : chk_wb
	// Branch with offset -2 words; target is pc + 4 - 8
	task automatic br(input logic [15:0] hi16, input logic [31:0] a, input logic [31:0] b,
		input logic tk, input logic nl);
		go({hi16, 16'hfffe}, a, b);
		chk("redirect", {31'h0, tk}, {31'h0, redirect});
		if (tk) begin
			chk("redirect_pc", 32'h0000_0ffc, redirect_pc);
		end
		chk("nullify", {31'h0, nl}, {31'h0, nullify_next});
	endtask : br
	task automatic t_branches;
		br(16'h1022, 32'h5, 32'h5, 1, 0);
		br(16'h1422, 32'h5, 32'h5, 0, 0);
		br(16'h1422, 32'h5, 32'h6, 1, 0);
		br(16'h1000, 32'h0, 32'h0, 1, 0);
		br(16'h0411, 32'h0, 32'h0, 1, 0);
		chk_wb(1, 5'h1f, 32'h0000_1008);
		br(16'h0421, 32'h8000_0000, 32'h0, 0, 0);
		br(16'h1c20, 32'h0, 32'h0, 0, 0);
		br(16'h1c20, 32'h1, 32'h0, 1, 0);
		br(16'h1820, 32'h0, 32'h0, 1, 0);
		br(16'h0420, 32'h8000_0000, 32'h0, 1, 0);
		br(16'h0430, 32'h1, 32'h0, 0, 0);
		chk_wb(1, 5'h1f, 32'h0000_1008);
		br(16'h5022, 32'h1, 32'h2, 0, 1);
		br(16'h0423, 32'hffff_ffff, 32'h0, 0, 1);
		br(16'h4908, 32'h0, 32'h0, 0, 0);
		br(16'h4909, 32'h0, 32'h0, 1, 0);
		br(16'h490a, 32'h0, 32'h0, 0, 1);
		br(16'h4903, 32'h0, 32'h0, 0, 1);
	endtask : t_branches
	task automatic t_alu;
		go(32'h2422_0020, 32'hffff_fff0, 32'h0);
		chk_wb(1, 5'd2, 32'h0000_0010);
		chk("overflow", 32'h0, {31'h0, exr});
		go(32'h7020_2820, 32'h0000_ffff, 32'h0);
		chk_wb(1, 5'd5, 32'd16);
		go(32'h7020_2820, 32'h0, 32'h0);
		chk_wb(1, 5'd5, 32'd32);
		go(32'h7020_2821, 32'hf000_0000, 32'h0);
		chk_wb(1, 5'd5, 32'd4);
		go(32'h7c23_3900, 32'h1234_5678, 32'h0);
		chk_wb(1, 5'd3, 32'h0000_0067);
		go(32'h7c23_5a04, 32'h0000_000a, 32'hffff_ffff);
		chk_wb(1, 5'd3, 32'hffff_faff);
		cmode = 1'b1;
		go(32'hec07_0010, 32'h0, 32'h0);
		chk_wb(1, 5'd7, 32'h0000_1010);
		cmode = 1'b0;
	endtask : t_alu
	task automatic t_div(input logic [5:0] fn, input logic [31:0] a, input logic [31:0] b,
		input logic [31:0] q, input logic [31:0] r);
		int n;
		go({26'h0020_000, fn}, a, b);
		idle();
		n = 0;
		while (busy !== 1'b0 && n < 40) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("quotient", q, lo);
		chk("remainder", r, hi);
	endtask : t_div
	task automatic t_cop;
		go(32'h48c5_1800, 32'h0, 32'hdead_beef);
		chk("ctrl_we", 32'h1, {31'h0, cop_ctrl_we});
		chk("ctrl_idx", 32'h3, {27'h0, cop_ctrl_idx});
		go(32'h4846_1800, 32'h0, 32'h0);
		chk_wb(1, 5'd6, 32'hdead_beef);
		cop_present = 1'b0;
		go(32'h48c5_1800, 32'h0, 32'h1);
		chk("cop_unusable", 32'h1, {31'h0, exu});
		chk("ctrl_we", 32'h0, {31'h0, cop_ctrl_we});
		go(32'hec07_0010, 32'h0, 32'h0);
		chk("reserved", 32'h1, {31'h0, exr});
		chk_wb(0, 5'd0, 32'h0);
		cop_present = 1'b1;
	endtask : t_cop
	// Status starts at 0x4: enable, disable, then two exception returns and a debug return
	task automatic t_status;
		go(32'h4164_6020, 32'h0, 32'h0);
		chk_wb(1, 5'd4, 32'h4);
		go(32'h4164_6000, 32'h0, 32'h0);
		chk("status", 32'h5, status_word);
		chk_wb(1, 5'd4, 32'h5);
		go(32'h4200_0018, 32'h0, 32'h0);
		chk("status", 32'h4, status_word);
		chk("redirect_pc", 32'h0000_3000, redirect_pc);
		go(32'h4200_0018, 32'h0, 32'h0);
		chk("redirect_pc", 32'h0000_2000, redirect_pc);
		go(32'h4200_001f, 32'h0, 32'h0);
		chk("redirect_pc", 32'h0000_4000, redirect_pc);
		idle();
		chk("status", 32'h0, status_word);
		chk("link_flag", 32'h0, {31'h0, llf});
		chk("debug_mode", 32'h0, {31'h0, dbg});
	endtask : t_status
	task automatic t_barrier;
		hazard_pending = 1'b1;
		go(32'h0000_00c0, 32'h0, 32'h0);
		idle();
		repeat (5) @(posedge mclk);
		#1;
		chk("busy", 32'h1, {31'h0, busy});
		hazard_pending = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk("busy", 32'h0, {31'h0, busy});
	endtask : t_barrier
	// Main sequence after 16 cycles of reset
	initial begin
		repeat (16) @(posedge mclk);
		#1;
		srst = 1'b0;
		t_branches();
		t_alu();
		t_cop();
		t_status();
		t_div(6'h1b, 32'd100, 32'd7, 32'd14, 32'd2);
		t_div(6'h1a, 32'hffff_fff9, 32'd2, 32'hffff_fffd, 32'hffff_ffff);
		t_barrier();
		test_done();
	end
endmodule : tb_top
`default_nettype wire
